// >>> design/prog_store_map.vh
`ifndef PROG_STORE_MAP_VH
`define PROG_STORE_MAP_VH
// ****************************************************************
// Register offsets on the software port
// ****************************************************************
`define OFF_TABLE_POINTER 4'h0
`define OFF_TABLE_HIGH_BYTE 4'h1
`define OFF_IRQ_ENABLE 4'h2
`define OFF_CORE_STATUS 4'h3
`define OFF_PROG_LOAD_ADDR_LO 4'h4
`define OFF_PROG_LOAD_ADDR_HI 4'h5
`define OFF_PROG_LOAD_DATA_LO 4'h6
`define OFF_PROG_LOAD_DATA_HI 4'h7
// ****************************************************************
// Vector addresses
// ****************************************************************
`define VEC_RESET 12'h000
`define VEC_EXT_ZERO 12'h004
`define VEC_EXT_ONE 12'h008
`define VEC_TIMER_ZERO 12'h00C
`define VEC_TIMER_ONE 12'h010
`define VEC_TIME_BASE 12'h014
`define VEC_RTC 12'h018
// ****************************************************************
// Reset values and fields
// ****************************************************************
`define RST_TABLE_POINTER 8'h00
`define RST_TABLE_HIGH_BYTE 8'h00
`define RST_IRQ_ENABLE 6'h00
`define LAST_PAGE_NIBBLE 4'hF
`define STACK_DEPTH 3'h4
`endif

// >>> design/program_rom_vector_table_read.v
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "prog_store_map.vh"
module program_rom_vector_table_read #(
   parameter ADDR_W = 12,
   parameter WORD_W = 15,
   parameter DEPTH = 4096
) (
   input wire clk_sys,
   input wire rst_n,
   input wire [3:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [7:0] regRdData,
   input wire cycleStrobe,
   input wire execDone,
   input wire [11:0] branchTarget,
   input wire branchTaken,
   input wire callPush,
   input wire returnPop,
   input wire [11:0] returnTarget,
   input wire readTableCurrentPage,
   input wire readTableLastPage,
   input wire [7:0] tableDestIn,
   input wire extIrqZero,
   input wire extIrqOne,
   input wire timerZeroOvf,
   input wire timerOneOvf,
   input wire timeBaseEvt,
   input wire rtcEvt,
   output reg [ADDR_W-1:0] programCounter,
   output reg [WORD_W-1:0] instrWord,
   output reg instrValid,
   output reg [7:0] tableLowByte,
   output reg [7:0] tableDest,
   output reg tableLowValid,
   output reg [ADDR_W-1:0] vectorAddr,
   output reg irqAck,
   output reg [5:0] irqPending
);

   // ****************************************************************
   // Storage and software registers
   // ****************************************************************
   // Program store array.
   reg [WORD_W-1:0] store [0:DEPTH-1];
   reg [7:0] tablePointer;
   reg [7:0] tableHighByte;
   reg [5:0] irqEnable;
   reg [11:0] loadAddr;
   reg [6:0] loadDataHi;
   reg [2:0] stackLevel;
   reg tableBusy;
   reg tableLast;
   reg [ADDR_W-1:0] tableAddr;
   reg [WORD_W-1:0] readWord;

   // External pins pass three flip-flops before edge detection.
   reg [1:0] syncZeroA;
   reg [1:0] syncOneA;
   reg syncZeroB;
   reg syncOneB;
   reg prevZero;
   reg prevOne;
   wire edgeZero;
   wire edgeOne;
   wire [5:0] irqEvent;
   wire stackFull;
   reg [5:0] next_pending;
   reg [2:0] winner;
   reg winnerFound;
   integer i;

   assign edgeZero = syncZeroB & ~prevZero;
   assign edgeOne = syncOneB & ~prevOne;
   assign irqEvent = {rtcEvt, timeBaseEvt, timerOneOvf, timerZeroOvf,
      edgeOne, edgeZero};
   assign stackFull = (stackLevel == `STACK_DEPTH);

   function [ADDR_W-1:0] vectorOf;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: begin
               vectorOf = `VEC_EXT_ZERO;
            end
            3'h1: begin
               vectorOf = `VEC_EXT_ONE;
            end
            3'h2: begin
               vectorOf = `VEC_TIMER_ZERO;
            end
            3'h3: begin
               vectorOf = `VEC_TIMER_ONE;
            end
            3'h4: begin
               vectorOf = `VEC_TIME_BASE;
            end
            3'h5: begin
               vectorOf = `VEC_RTC;
            end
            default: begin
               vectorOf = `VEC_RESET;
            end
         endcase
      end
   endfunction

   // ****************************************************************
   // Interrupt arbitration
   // ****************************************************************
   // Lowest vector wins, matching the order of the vector table.
   always @* begin
      winner = 3'h0;
      winnerFound = 1'b0;
      for (i = 5; i >= 0; i = i - 1) begin
         if (irqPending[i] & irqEnable[i]) begin
            winner = i[2:0];
            winnerFound = 1'b1;
         end
      end
   end

   // Requests latch; set wins over acknowledge clear.
   always @* begin
      next_pending = irqPending;
      if (irqAck) begin
         next_pending[winner] = 1'b0;
      end
      next_pending = next_pending | (irqEvent & irqEnable);
   end

   // The fourth stage only remembers the last level for edge detection.
   // A pulse shorter than one clock may be missed by the synchroniser.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         syncZeroA <= 2'h0;
         syncOneA <= 2'h0;
         syncZeroB <= 1'b0;
         syncOneB <= 1'b0;
         prevZero <= 1'b0;
         prevOne <= 1'b0;
      end else begin
         syncZeroA <= {syncZeroA[0], extIrqZero};
         syncOneA <= {syncOneA[0], extIrqOne};
         syncZeroB <= syncZeroA[1];
         syncOneB <= syncOneA[1];
         prevZero <= syncZeroB;
         prevOne <= syncOneB;
      end
   end

   // ****************************************************************
   // Software port
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (regWrite) begin
         if (regAddr == `OFF_PROG_LOAD_DATA_LO) begin
            store[loadAddr] <= {loadDataHi, regWrData};
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         tablePointer <= `RST_TABLE_POINTER;
         irqEnable <= `RST_IRQ_ENABLE;
         loadAddr <= 12'h000;
         loadDataHi <= 7'h00;
         regRdData <= 8'h00;
      end else begin
         if (regWrite) begin
            case (regAddr)
               `OFF_TABLE_POINTER: begin
                  tablePointer <= regWrData;
               end
               `OFF_IRQ_ENABLE: begin
                  irqEnable <= regWrData[5:0];
               end
               `OFF_PROG_LOAD_ADDR_LO: begin
                  loadAddr[7:0] <= regWrData;
               end
               `OFF_PROG_LOAD_ADDR_HI: begin
                  loadAddr[11:8] <= regWrData[3:0];
               end
               `OFF_PROG_LOAD_DATA_HI: begin
                  loadDataHi <= regWrData[6:0];
               end
               `OFF_PROG_LOAD_DATA_LO: begin
                  loadAddr <= loadAddr + 12'h001;
               end
               // Writes to the high-byte offset are ignored.
               default: begin
                  loadAddr <= loadAddr;
               end
            endcase
         end
         regRdData <= 8'h00;
         if (regRead) begin
            case (regAddr)
               `OFF_TABLE_POINTER: begin
                  regRdData <= tablePointer;
               end
               `OFF_TABLE_HIGH_BYTE: begin
                  regRdData <= tableHighByte;
               end
               `OFF_IRQ_ENABLE: begin
                  regRdData <= {2'h0, irqEnable};
               end
               `OFF_CORE_STATUS: begin
                  regRdData <= {4'h0, tableBusy, stackLevel};
               end
               `OFF_PROG_LOAD_ADDR_LO: begin
                  regRdData <= loadAddr[7:0];
               end
               `OFF_PROG_LOAD_ADDR_HI: begin
                  regRdData <= {4'h0, loadAddr[11:8]};
               end
               default: begin
                  regRdData <= 8'h00;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Fetch, vectors and table reads
   // ****************************************************************
   // Table address built from page and pointer.
   always @* begin
      tableAddr = {programCounter[11:8], tablePointer};
      if (tableLast) begin
         tableAddr = {`LAST_PAGE_NIBBLE, tablePointer};
      end
   end

   // Synchronous read keeps the store inferable as block memory.
   // Busy table read owns the store port.
   always @(posedge clk_sys) begin
      if (tableBusy) begin
         readWord <= store[tableAddr];
      end else begin
         readWord <= store[programCounter];
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         programCounter <= `VEC_RESET;
         instrWord <= 15'h0000;
         instrValid <= 1'b0;
         tableHighByte <= `RST_TABLE_HIGH_BYTE;
         tableLowByte <= 8'h00;
         tableDest <= 8'h00;
         tableLowValid <= 1'b0;
         tableBusy <= 1'b0;
         tableLast <= 1'b0;
         vectorAddr <= `VEC_RESET;
         irqAck <= 1'b0;
         irqPending <= 6'h00;
         stackLevel <= 3'h0;
      end else begin
         irqPending <= next_pending;
         irqAck <= 1'b0;
         instrValid <= 1'b0;
         tableLowValid <= 1'b0;
         if (cycleStrobe) begin
            if (tableBusy) begin
               // Second cycle delivers the table word.
               tableBusy <= 1'b0;
               tableLowValid <= 1'b1;
               // Split word into low and high parts.
               tableLowByte <= readWord[7:0];
               // Top bit of the high byte is zero.
               tableHighByte <= {1'b0, readWord[14:8]};
            end else if (readTableCurrentPage | readTableLastPage) begin
               tableBusy <= 1'b1;
               tableLast <= readTableLastPage;
               tableDest <= tableDestIn;
            end else if (winnerFound & ~stackFull & execDone) begin
               // Acknowledge only with a free stack level.
               irqAck <= 1'b1;
               vectorAddr <= vectorOf(winner);
               programCounter <= vectorOf(winner);
               stackLevel <= stackLevel + 3'h1;
            end else begin
               instrWord <= readWord;
               instrValid <= 1'b1;
               if (returnPop & (stackLevel != 3'h0)) begin
                  programCounter <= returnTarget;
                  stackLevel <= stackLevel - 3'h1;
               end else if (branchTaken) begin
                  // A call on a full stack is not counted, so software
                  // must keep its nesting within the stack depth.
                  programCounter <= branchTarget;
                  if (callPush & ~stackFull) begin
                     stackLevel <= stackLevel + 3'h1;
                  end
               end else begin
                  programCounter <= programCounter + 12'h001;
               end
            end
         end
      end
   end

endmodule

// >>> verif/core_pace_model.sv
`timescale 1ns/100ps
// ****
// Core pacing
// ****
module core_pace_model (
   input wire clk_sys,
   input wire rst_n,
   output reg cycleStrobe,
   output wire execDone
);
   reg [1:0] phase;
   // Four clocks form one instruction cycle, so the strobe is sparse.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         phase <= 2'h0;
         cycleStrobe <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         cycleStrobe <= (phase == 2'h3);
      end
   end
   // Each modelled instruction ends at its cycle boundary.
   assign execDone = 1'b1;
endmodule

// >>> verif/prog_store_props.sv
`timescale 1ns/100ps
module prog_store_props #(
   parameter ADDR_W = 12,
   parameter WORD_W = 15
) (
   input wire clk_sys,
   input wire rst_n,
   input wire [3:0] regAddr,
   input wire regRead,
   input wire [7:0] regRdData,
   input wire cycleStrobe,
   input wire [ADDR_W-1:0] programCounter,
   input wire instrValid,
   input wire tableLowValid,
   input wire [ADDR_W-1:0] vectorAddr,
   input wire irqAck
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_reset_pc: assert property ($rose(rst_n) |-> programCounter == 12'h000)
      else $error("pc not at reset vector");
   chk_pc_steady: assert property (!cycleStrobe |=> $stable(programCounter))
      else $error("pc moved off strobe");
   chk_vector_set: assert property (irqAck |-> vectorAddr inside {12'h004,
      12'h008, 12'h00C, 12'h010, 12'h014, 12'h018})
      else $error("bad vector");
   chk_ack_strobe: assert property (irqAck |-> $past(cycleStrobe) ##1 !irqAck)
      else $error("ack off strobe");
   chk_table_pulse: assert property (tableLowValid |=> !tableLowValid)
      else $error("table valid too long");
   chk_table_strobe: assert property (tableLowValid |-> $past(cycleStrobe))
      else $error("table valid off strobe");
   chk_table_nofetch: assert property (tableLowValid |-> !instrValid)
      else $error("fetch during table read");
   chk_high_bit: assert property (regRead && regAddr == 4'h1 |=> !regRdData[7])
      else $error("high byte bit seven set");
   chk_read_idle: assert property (!regRead |=> regRdData == 8'h00)
      else $error("read data without read");
   cover property (irqAck);
   cover property (tableLowValid);
   cover property (regRead && regAddr == 4'h1);
endmodule
bind program_rom_vector_table_read prog_store_props #(.ADDR_W(ADDR_W),
   .WORD_W(WORD_W)) i_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData),
   .cycleStrobe(cycleStrobe), .programCounter(programCounter),
   .instrValid(instrValid), .tableLowValid(tableLowValid),
   .vectorAddr(vectorAddr), .irqAck(irqAck));

// >>> verif/program_rom_vector_table_read_test.sv
`timescale 1ns/100ps
module program_rom_vector_table_read_test;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [3:0] regAddr = 4'h0;
   reg [7:0] regWrData = 8'h00;
   reg regWrite = 1'b0;
   reg regRead = 1'b0;
   reg [11:0] branchTarget = 12'h340;
   reg [4:0] req = 5'h00;
   reg [7:0] tableDestIn = 8'h00;
   reg [5:0] evt = 6'h00;
   reg [7:0] d;
   integer errTotal = 0;
   integer comparisons = 0;
   integer i;
   integer n;
   wire cycleStrobe, execDone, instrValid, tableLowValid, irqAck;
   wire [7:0] regRdData, tableLowByte, tableDest;
   wire [11:0] programCounter, vectorAddr;
   wire [14:0] instrWord;
   wire [5:0] irqPending;
   wire [2:0] flags = {irqAck, tableLowValid, cycleStrobe};
   core_pace_model i_core (.clk_sys(clk_sys), .rst_n(rst_n),
      .cycleStrobe(cycleStrobe), .execDone(execDone));
   program_rom_vector_table_read i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .cycleStrobe(cycleStrobe),
      .execDone(execDone), .branchTarget(branchTarget),
      .branchTaken(req[4]), .callPush(req[3]), .returnPop(req[2]),
      .returnTarget(12'h000), .readTableCurrentPage(req[1]),
      .readTableLastPage(req[0]), .tableDestIn(tableDestIn),
      .extIrqZero(evt[0]), .extIrqOne(evt[1]), .timerZeroOvf(evt[2]),
      .timerOneOvf(evt[3]), .timeBaseEvt(evt[4]), .rtcEvt(evt[5]),
      .programCounter(programCounter), .instrWord(instrWord),
      .instrValid(instrValid), .tableLowByte(tableLowByte),
      .tableDest(tableDest), .tableLowValid(tableLowValid),
      .vectorAddr(vectorAddr), .irqAck(irqAck), .irqPending(irqPending));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task check(input [63:0] what, input [15:0] seen, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            errTotal = errTotal + 1;
            $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task closeOut;
      begin
         $display("checks %0d mismatches %0d", comparisons, errTotal);
         if (errTotal == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // A wait that runs out of its bound ends the run.
   task await(input integer b, input integer lim);
      begin
         n = 0;
         do begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
         end while (flags[b] !== 1'b1 && n < lim);
         check("wait", flags[b], 1'b1);
         if (flags[b] !== 1'b1)
            closeOut;
         // Realign to the edge that takes the level seen high here.
         @(posedge clk_sys);
      end
   endtask
   task wr(input [3:0] a, input [7:0] v);
      begin
         regAddr <= a;
         regWrData <= v;
         regWrite <= 1'b1;
         @(posedge clk_sys);
         regWrite <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task rd(input [3:0] a, output [7:0] v);
      begin
         regAddr <= a;
         regRead <= 1'b1;
         @(posedge clk_sys);
         regRead <= 1'b0;
         #1;
         v = regRdData;
         @(posedge clk_sys);
      end
   endtask
   // Core requests are held until a strobe edge has taken them.
   task core(input [4:0] m);
      begin
         await(0, 9);
         req <= m;
         await(0, 9);
         req <= 5'h00;
         @(posedge clk_sys);
      end
   endtask
   task load(input [11:0] a, input [14:0] w);
      begin
         wr(4'h4, a[7:0]);
         wr(4'h5, {4'h0, a[11:8]});
         wr(4'h7, {1'b0, w[14:8]});
         wr(4'h6, w[7:0]);
      end
   endtask
   task tread(input [4:0] m, input [7:0] tp, input [14:0] w);
      begin
         wr(4'h0, tp);
         tableDestIn <= tp;
         core(m);
         await(1, 12);
         check("lowb", tableLowByte, w[7:0]);
         check("dest", tableDest, tp);
         rd(4'h1, d);
         check("high", d, {1'b0, w[14:8]});
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      check("pc", programCounter, 12'h000);
      rd(4'h0, d);
      check("tp", d, 8'h00);
      rd(4'hF, d);
      check("unmap", d, 8'h00);
      $display("reset test done");
      for (i = 0; i < 6; i = i + 1) begin
         wr(4'h2, 8'h01 << i);
         evt <= 6'h01 << i;
         @(posedge clk_sys);
         evt <= 6'h00;
         await(2, 40);
         check("vec", vectorAddr, 12'h004 * (i + 1));
         core(5'h04);
      end
      $display("vector test done");
      // Interrupts are masked so no vector moves the program counter off the table page.
      wr(4'h2, 8'h00);
      load(12'hF06, 15'h5A1A);
      load(12'h344, 15'h7FC3);
      branchTarget <= 12'h340;
      core(5'h10);
      tread(5'h01, 8'h06, 15'h5A1A);
      tread(5'h02, 8'h44, 15'h7FC3);
      wr(4'h1, 8'h00);
      rd(4'h1, d);
      check("rdonly", d, 8'h7F);
      $display("table test done");
      for (i = 0; i < 4; i = i + 1)
         core(5'h18);
      wr(4'h2, 8'h20);
      evt <= 6'h20;
      @(posedge clk_sys);
      evt <= 6'h00;
      i = 0;
      repeat (16) begin
         @(posedge clk_sys);
         if (irqAck === 1'b1)
            i = i + 1;
      end
      check("noack", i, 0);
      check("pend", irqPending[5], 1'b1);
      core(5'h04);
      await(2, 40);
      check("vec", vectorAddr, 12'h018);
      $display("full stack test done");
      closeOut;
   end
endmodule
